// File: hdl/eda_pkg.sv
// Constants, register layout and state types for the data store access block.
// Assumes a single 25 MHz CPU clock and a 6-bit I/O register address space.
package eda_pkg;

    // I/O register addresses
    localparam logic [5:0] EDA_OFS_CTRL   = 6'h1f;
    localparam logic [5:0] EDA_OFS_DATA   = 6'h20;
    localparam logic [5:0] EDA_OFS_ADDR_L = 6'h21;
    localparam logic [5:0] EDA_OFS_ADDR_H = 6'h22;

    // Control register field positions
    localparam int EDA_BIT_READ_STROBE  = 0;
    localparam int EDA_BIT_WRITE_STROBE = 1;
    localparam int EDA_BIT_MASTER_WE    = 2;
    localparam int EDA_BIT_READY_IE     = 3;
    localparam int EDA_BIT_MODE_LO      = 4;

    // Geometry
    localparam int EDA_ADDR_W = 9;
    localparam int EDA_DEPTH  = 512;

    // Programming modes
    localparam logic [1:0] EDA_MODE_ATOMIC     = 2'h0;
    localparam logic [1:0] EDA_MODE_ERASE      = 2'h1;
    localparam logic [1:0] EDA_MODE_WRITE_ONLY = 2'h2;

    // Reset values and the erased byte value
    localparam logic [8:0] EDA_RST_ADDR = 9'h000;
    localparam logic [7:0] EDA_RST_DATA = 8'h00;
    localparam logic [1:0] EDA_RST_MODE = 2'h0;
    localparam logic [7:0] EDA_ERASED   = 8'hff;

    // Timing
    localparam int EDA_CLK_NS        = 40;
    localparam int EDA_T_ATOMIC_NS   = 3400000;
    localparam int EDA_T_SPLIT_NS    = 1800000;
    localparam int EDA_ATOMIC_CYCLES = (EDA_T_ATOMIC_NS + EDA_CLK_NS - 1) / EDA_CLK_NS;
    localparam int EDA_SPLIT_CYCLES  = (EDA_T_SPLIT_NS + EDA_CLK_NS - 1) / EDA_CLK_NS;
    localparam int EDA_PROG_CNT_W    = 17;
    localparam logic [2:0] EDA_MWE_WINDOW  = 3'h4;
    localparam logic [2:0] EDA_READ_STALL  = 3'h4;
    localparam logic [2:0] EDA_WRITE_STALL = 3'h2;

    typedef enum logic [1:0] {
        PS_IDLE     = 2'b00,
        PS_RD_FETCH = 2'b01,
        PS_WR_FETCH = 2'b10,
        PS_WR_WAIT  = 2'b11
    } eda_state_t;

endpackage

// File: hdl/eda_nv_mem.sv
// Byte-wide storage array for the nonvolatile data space.
// Assumes one access per cycle; read data is registered and valid one cycle after mem_re.
`timescale 1ns/1ns
module eda_nv_mem
    import eda_pkg::*;
(
    // Clock
    input  wire logic                  clk,
    // Access port
    input  wire logic                  mem_re,
    input  wire logic                  mem_we,
    input  wire logic [EDA_ADDR_W-1:0] mem_addr,
    input  wire logic [7:0]            mem_wdata,
    output      logic [7:0]            mem_rdata
);

    logic [7:0] array_q [EDA_DEPTH];

    // No reset: the array models retained contents
    always_ff @(posedge clk)
    begin
        if (mem_we)
        begin
            array_q[mem_addr] <= mem_wdata;
        end
        if (mem_re)
        begin
            mem_rdata <= array_q[mem_addr];
        end
    end

endmodule

// File: hdl/eda_nv_access.sv
// CPU-side access logic for the 512-byte nonvolatile data store.
// Assumes the CPU core drives at most one I/O access per cycle and obeys CPU_STALL.
//
// Notes on behaviour
// R1: A separate 512-byte store, every byte readable and writable alone.
// R2: Linear 9-bit address 0..511; bit 8 in high register, bits 7..0 low.
// R3: High address register bits 15..9 always read zero.
// R4: Address after reset is undefined; any reset value is acceptable.
// R5: The CPU loads a valid address before starting a read or write.
// R6: A write programs the data register byte at the current address.
// R7: A read puts the byte at the current address into the data register.
// R8: Address, data and control registers sit in the CPU I/O space.
// R9: A read stalls the CPU for four clock cycles; here two if the same control write also sets an enabled write strobe.
// R10: Starting a write stalls the CPU for two clock cycles.
// R11: Writes are self-timed; a pollable bit shows when the next may start.
// R12: A write needs the enabling sequence; the CPU follows it every time.
// R13: Master write enable self-clears four cycles after software sets it.
// R14: Write strobe starts programming only within four cycles of master enable.
// R15: Hardware clears the write strobe when the programming time has elapsed.
// R16: Read strobe completes the read so data is available right after.
// R17: Writes to reserved high address bits are ignored and do not matter.
`timescale 1ns/1ns
module eda_nv_access
    import eda_pkg::*;
#(
    parameter int ATOMIC_CYCLES = EDA_ATOMIC_CYCLES,
    parameter int SPLIT_CYCLES  = EDA_SPLIT_CYCLES
)
(
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RSTN,
    // CPU I/O register port
    input  wire logic [5:0] IO_ADDR,
    input  wire logic       IO_WE,
    input  wire logic       IO_RE,
    input  wire logic [7:0] IO_WDATA,
    output      logic [7:0] IO_RDATA,
    // CPU hold
    output      logic       CPU_STALL
);
    import eda_pkg::*;

    typedef struct packed {
        logic [EDA_ADDR_W-1:0]     addr;
        logic [7:0]                data;
        logic [1:0]                mode;
        logic                      ready_ie;
        logic                      master_we;
        logic                      write_strobe;
        logic                      read_strobe;
        logic [2:0]                mwe_cnt;
        logic [2:0]                stall_cnt;
        logic                      stall;
        eda_state_t                state;
        logic [EDA_PROG_CNT_W-1:0] prog_cnt;
        logic [7:0]                prog_data;
        logic [7:0]                rdata;
    } eda_regs_t;

    eda_regs_t  s_q;
    eda_regs_t  s_d;
    logic       ctrl_wr;
    logic       rd_acc;
    logic       wr_acc;
    logic       mem_re;
    logic       mem_we;
    logic [7:0] mem_rdata;

    function automatic logic [7:0] ctrl_byte(input eda_regs_t s);
        ctrl_byte = {2'h0, s.mode, s.ready_ie, s.master_we, s.write_strobe, s.read_strobe};
    endfunction

    function automatic logic [EDA_PROG_CNT_W-1:0] prog_time(input logic [1:0] mode);
        if (mode == EDA_MODE_ERASE || mode == EDA_MODE_WRITE_ONLY)
            prog_time = EDA_PROG_CNT_W'(SPLIT_CYCLES);
        else
            prog_time = EDA_PROG_CNT_W'(ATOMIC_CYCLES);
    endfunction

    assign ctrl_wr = IO_WE && (IO_ADDR == EDA_OFS_CTRL);
    // Strobes are ignored while the CPU should be stalled or a write is pending
    assign rd_acc  = ctrl_wr && IO_WDATA[EDA_BIT_READ_STROBE] && !s_q.write_strobe
                     && (s_q.stall_cnt == 3'h0) && (s_q.state == PS_IDLE);            // [R16]
    assign wr_acc  = ctrl_wr && IO_WDATA[EDA_BIT_WRITE_STROBE] && s_q.master_we
                     && !s_q.write_strobe && (s_q.stall_cnt == 3'h0)
                     && (s_q.state == PS_IDLE);                                       // [R12] [R14]
    // Old contents are fetched on both strobes; write-only mode merges with them
    assign mem_re  = rd_acc || wr_acc;
    assign mem_we  = (s_q.state == PS_WR_WAIT) && (s_q.prog_cnt == '0);              // [R6] [R11]

    eda_nv_mem u_mem (
        .clk       (CLK),
        .mem_re    (mem_re),
        .mem_we    (mem_we),
        .mem_addr  (s_q.addr),
        .mem_wdata (s_q.prog_data),
        .mem_rdata (mem_rdata)
    );                                                                               // [R1] [R2]

    always_comb
    begin
        s_d = s_q;
        // Register writes from the CPU
        if (IO_WE)
        begin
            unique case (IO_ADDR)
                EDA_OFS_ADDR_L:
                    if (!s_q.write_strobe)
                        s_d.addr[7:0] = IO_WDATA;                                    // [R2] [R8]
                EDA_OFS_ADDR_H:
                    if (!s_q.write_strobe)
                        s_d.addr[8] = IO_WDATA[0];                                   // [R17]
                EDA_OFS_DATA:
                    s_d.data = IO_WDATA;
                EDA_OFS_CTRL:
                begin
                    s_d.ready_ie = IO_WDATA[EDA_BIT_READY_IE];
                    if (!s_q.write_strobe)
                        s_d.mode = IO_WDATA[EDA_BIT_MODE_LO +: 2];
                    if (!IO_WDATA[EDA_BIT_MASTER_WE])
                    begin
                        s_d.master_we = 1'b0;
                        s_d.mwe_cnt   = 3'h0;
                    end
                    else if (!s_q.master_we)
                    begin
                        s_d.master_we = 1'b1;
                        s_d.mwe_cnt   = EDA_MWE_WINDOW;
                    end
                end
                default:
                begin
                end
            endcase
        end
        // Master enable window; a fresh set is not counted down in its own cycle
        if (s_q.master_we && s_q.mwe_cnt != 3'h0)
        begin
            s_d.mwe_cnt = s_q.mwe_cnt - 3'h1;
            if (s_q.mwe_cnt == 3'h1)
                s_d.master_we = 1'b0;                                                // [R13]
        end
        // CPU hold counter
        if (s_q.stall_cnt != 3'h0)
            s_d.stall_cnt = s_q.stall_cnt - 3'h1;
        if (rd_acc)
            s_d.stall_cnt = EDA_READ_STALL;                                          // [R9]
        if (wr_acc)
            s_d.stall_cnt = EDA_WRITE_STALL;                                         // [R10]
        s_d.stall = (s_d.stall_cnt != 3'h0);
        // Access sequencer
        unique case (s_q.state)
            PS_IDLE:
            begin
                if (rd_acc)
                begin
                    s_d.read_strobe = 1'b1;
                    s_d.state       = PS_RD_FETCH;
                end
                else if (wr_acc)
                begin
                    s_d.write_strobe = 1'b1;
                    s_d.state        = PS_WR_FETCH;
                end
            end
            PS_RD_FETCH:
            begin
                s_d.data        = mem_rdata;                                         // [R7] [R16]
                s_d.read_strobe = 1'b0;
                s_d.state       = PS_IDLE;
            end
            PS_WR_FETCH:
            begin
                // Latching here keeps later data register writes out of the programmed byte
                unique case (s_q.mode)
                    EDA_MODE_ERASE:      s_d.prog_data = EDA_ERASED;
                    EDA_MODE_WRITE_ONLY: s_d.prog_data = mem_rdata & s_q.data;
                    default:             s_d.prog_data = s_q.data;                   // [R6]
                endcase
                s_d.prog_cnt = prog_time(s_q.mode);
                s_d.state    = PS_WR_WAIT;
            end
            PS_WR_WAIT:
            begin
                // The array is written in the cycle the count reaches zero
                if (s_q.prog_cnt == '0)
                begin
                    s_d.write_strobe = 1'b0;                                         // [R15] [R11]
                    s_d.state        = PS_IDLE;
                end
                else
                    s_d.prog_cnt = s_q.prog_cnt - EDA_PROG_CNT_W'(1);
            end
        endcase
        // Registered read data
        if (IO_RE)
        begin
            unique case (IO_ADDR)
                EDA_OFS_ADDR_L: s_d.rdata = s_q.addr[7:0];
                EDA_OFS_ADDR_H: s_d.rdata = {7'h00, s_q.addr[8]};                   // [R3]
                EDA_OFS_DATA:   s_d.rdata = s_q.data;
                EDA_OFS_CTRL:   s_d.rdata = ctrl_byte(s_q);
                default:        s_d.rdata = 8'h00;
            endcase
        end
    end

    // The array keeps its contents over reset; only the access state is cleared
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            s_q.addr         <= EDA_RST_ADDR;                                        // [R4]
            s_q.data         <= EDA_RST_DATA;
            s_q.mode         <= EDA_RST_MODE;
            s_q.ready_ie     <= 1'b0;
            s_q.master_we    <= 1'b0;
            s_q.write_strobe <= 1'b0;
            s_q.read_strobe  <= 1'b0;
            s_q.mwe_cnt      <= 3'h0;
            s_q.stall_cnt    <= 3'h0;
            s_q.stall        <= 1'b0;
            s_q.state        <= PS_IDLE;
            s_q.prog_cnt     <= '0;
            s_q.prog_data    <= EDA_RST_DATA;
            s_q.rdata        <= 8'h00;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign IO_RDATA  = s_q.rdata;
    assign CPU_STALL = s_q.stall;

    // Every check runs on the CPU clock and is muted while reset is held
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // Hold lengths count the cycles in which the core is frozen
    sequence seq_read_hold;
        CPU_STALL [*4] ##1 !CPU_STALL;
    endsequence

    sequence seq_write_hold;
        CPU_STALL [*2] ##1 !CPU_STALL;
    endsequence

    sequence seq_write_start;
        s_q.write_strobe && (s_q.state == PS_WR_FETCH) ##1 s_q.write_strobe && (s_q.state == PS_WR_WAIT);
    endsequence

    a_read_stall_len: assert property (rd_acc |=> seq_read_hold)                     // [R9]
        else $error("read stall is not four cycles");
    a_write_stall_len: assert property (wr_acc |=> seq_write_hold)                   // [R10]
        else $error("write stall is not two cycles");
    a_mwe_timeout: assert property ($rose(s_q.master_we) |-> ##4 !s_q.master_we)     // [R13]
        else $error("master write enable did not time out after four cycles");
    a_write_needs_mwe: assert property (                                             // [R12] [R14]
        ctrl_wr && IO_WDATA[EDA_BIT_WRITE_STROBE] && !s_q.master_we && !s_q.write_strobe
        |=> !s_q.write_strobe)
        else $error("write started without master enable");
    a_read_data_load: assert property (                                              // [R7] [R16]
        rd_acc |-> ##2 (s_q.data == $past(mem_rdata)) && !s_q.read_strobe)
        else $error("read data not loaded two cycles after strobe");
    a_write_commit: assert property (                                                // [R15]
        mem_we |-> (s_q.prog_data == $past(s_q.prog_data)) ##1 !s_q.write_strobe)
        else $error("write strobe not cleared after programming");
    // The strobe write loads the mode too, so the mode in force is taken from the bus
    a_write_value: assert property (                                                 // [R6]
        wr_acc && IO_WDATA[EDA_BIT_MODE_LO +: 2] == EDA_MODE_ATOMIC
        |-> ##2 s_q.prog_data == $past(s_q.data, 2))
        else $error("programmed byte differs from data register");
    a_erase_value: assert property (                                                 // [R6]
        wr_acc && IO_WDATA[EDA_BIT_MODE_LO +: 2] == EDA_MODE_ERASE |-> ##2 s_q.prog_data == EDA_ERASED)
        else $error("erase does not program the erased value");
    // Write-only can only clear bits, so the old byte is merged by AND
    a_merge_value: assert property (                                                 // [R6]
        wr_acc && IO_WDATA[EDA_BIT_MODE_LO +: 2] == EDA_MODE_WRITE_ONLY
        |-> ##2 s_q.prog_data == ($past(mem_rdata) & $past(s_q.data, 2)))
        else $error("write-only byte is not merged with the old contents");
    a_write_start: assert property (wr_acc |=> seq_write_start)                     // [R11]
        else $error("write sequencer did not start after an accepted strobe");
    a_write_busy: assert property (s_q.write_strobe && !mem_we |=> s_q.write_strobe) // [R11] [R15]
        else $error("write strobe dropped before the array was written");
    // Modes 01 and 10 are the split operations with the shorter time
    a_prog_time: assert property (                                                   // [R11]
        $rose(s_q.state == PS_WR_WAIT)
        |-> s_q.prog_cnt == EDA_PROG_CNT_W'((^s_q.mode) ? SPLIT_CYCLES : ATOMIC_CYCLES))
        else $error("programming time does not match the mode");
    a_addr_high_zero: assert property (                                              // [R3]
        IO_RE && IO_ADDR == EDA_OFS_ADDR_H |=> IO_RDATA[7:1] == 7'h00)
        else $error("reserved high address bits read nonzero");
    a_high_bit_only: assert property (                                               // [R17] [R2]
        IO_WE && IO_ADDR == EDA_OFS_ADDR_H && !s_q.write_strobe
        |=> s_q.addr[8] == $past(IO_WDATA[0]) && $stable(s_q.addr[7:0]))
        else $error("high address write did not load bit 8 alone");
    // An address change mid-write would program the wrong byte
    a_addr_frozen: assert property (s_q.state == PS_WR_WAIT |=> $stable(s_q.addr))  // [R6]
        else $error("address changed during programming");

endmodule

// File: testbench/eda_cpu_model.sv
// CPU core model on the I/O register side of the nonvolatile access block.
// Assumes the bench top is test_eda_nv_access; a stuck stall ends the run there.
`timescale 1ns/1ns
module eda_cpu_model
    import eda_pkg::*;
(
    // Clock and hold
    input  wire logic       clk,
    input  wire logic       cpu_stall,
    // I/O register port
    output      logic [5:0] io_addr,
    output      logic       io_we,
    output      logic       io_re,
    output      logic [7:0] io_wdata,
    input  wire logic [7:0] io_rdata
);
    initial
    begin
        io_addr  = 6'h00;
        io_we    = 1'b0;
        io_re    = 1'b0;
        io_wdata = 8'h00;
    end

    // A halted core issues nothing, so every access first waits out the stall
    task automatic wait_go();
        int n;
        n = 0;
        @(negedge clk);
        while (cpu_stall !== 1'b0)
        begin
            @(negedge clk);
            n++;
            if (n > 50)
                test_eda_nv_access.test_done(1'b1);
        end
    endtask

    task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
        wait_go();
        io_addr  = a;
        io_wdata = d;
        io_we    = 1'b1;
        @(negedge clk);
        io_we    = 1'b0;
        // Released data lines do not keep the last value
        io_wdata = ~d;
    endtask

    task automatic io_rd(input logic [5:0] a, output logic [7:0] d);
        wait_go();
        io_addr = a;
        io_re   = 1'b1;
        @(negedge clk);
        io_re = 1'b0;
        @(negedge clk);
        d = io_rdata;
    endtask

    task automatic set_addr(input logic [8:0] a);
        io_wr(EDA_OFS_ADDR_H, {7'h00, a[8]});
        io_wr(EDA_OFS_ADDR_L, a[7:0]);
    endtask

    // Without a gap the strobe lands two cycles after the enable; each gap cycle adds one
    task automatic nv_write(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m, input int gap);
        set_addr(a);
        io_wr(EDA_OFS_DATA, d);
        io_wr(EDA_OFS_CTRL, {2'h0, m, 4'h4});
        repeat (gap) @(negedge clk);
        io_wr(EDA_OFS_CTRL, {2'h0, m, 4'h6});
    endtask

    task automatic nv_read(input logic [8:0] a);
        set_addr(a);
        io_wr(EDA_OFS_CTRL, 8'h01);
    endtask
endmodule

// File: testbench/test_eda_nv_access.sv
// Self-checking bench for the nonvolatile data store access block.
// Assumes programming times shortened through the top parameters.
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; $display("ERROR %0t mismatch got %h exp %h", $time, g, e); end end
module test_eda_nv_access;
    import eda_pkg::*;
    logic       CLK;
    logic       RSTN;
    logic [5:0] IO_ADDR;
    logic       IO_WE;
    logic       IO_RE;
    logic [7:0] IO_WDATA;
    logic [7:0] IO_RDATA;
    logic       CPU_STALL;
    logic [7:0] rd;
    int         err_count;
    int         checked;

    eda_nv_access #(.ATOMIC_CYCLES(20), .SPLIT_CYCLES(10)) uut (
        .CLK(CLK), .RSTN(RSTN), .IO_ADDR(IO_ADDR), .IO_WE(IO_WE), .IO_RE(IO_RE),
        .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .CPU_STALL(CPU_STALL));
    eda_cpu_model cpu (
        .clk(CLK), .cpu_stall(CPU_STALL), .io_addr(IO_ADDR), .io_we(IO_WE), .io_re(IO_RE),
        .io_wdata(IO_WDATA), .io_rdata(IO_RDATA));

    always #20 CLK = ~CLK;

    task automatic test_done(input bit hung);
        if (hung)
            err_count++;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Every cycle is sampled once, so the count equals the hold length
    task automatic count_stall(output int n);
        n = 0;
        repeat (8)
        begin
            if (CPU_STALL === 1'b1)
                n++;
            @(negedge CLK);
        end
    endtask

    task automatic wait_ready();
        for (int i = 0; i < 40; i++)
        begin
            cpu.io_rd(EDA_OFS_CTRL, rd);
            if (rd[EDA_BIT_WRITE_STROBE] === 1'b0)
                return;
        end
        test_done(1'b1);
    endtask

    task automatic do_write(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m, input int gap);
        int n;
        cpu.nv_write(a, d, m, gap);
        count_stall(n);
        `CHK(n, 2)
        cpu.io_rd(EDA_OFS_CTRL, rd);
        `CHK(rd[EDA_BIT_WRITE_STROBE], 1'b1)
        wait_ready();
    endtask

    task automatic do_read(input logic [8:0] a, input logic [7:0] e);
        int n;
        cpu.nv_read(a);
        count_stall(n);
        `CHK(n, 4)
        cpu.io_rd(EDA_OFS_DATA, rd);
        `CHK(rd, e)
    endtask

    task automatic t_regs();
        cpu.io_rd(EDA_OFS_ADDR_H, rd);
        `CHK(rd[7:1], 7'h00)
        cpu.io_wr(EDA_OFS_ADDR_H, 8'hff);
        cpu.io_rd(EDA_OFS_ADDR_H, rd);
        `CHK(rd, 8'h01)
        cpu.io_wr(EDA_OFS_ADDR_L, 8'ha5);
        cpu.io_rd(EDA_OFS_ADDR_L, rd);
        `CHK(rd, 8'ha5)
        cpu.io_wr(EDA_OFS_DATA, 8'h3c);
        cpu.io_rd(EDA_OFS_DATA, rd);
        `CHK(rd, 8'h3c)
        cpu.io_wr(EDA_OFS_CTRL, 8'hf8);
        cpu.io_rd(EDA_OFS_CTRL, rd);
        `CHK(rd, 8'h38)
        cpu.io_wr(EDA_OFS_CTRL, 8'h00);
        cpu.io_rd(6'h00, rd);
        `CHK(rd, 8'h00)
        $display("t_regs done");
    endtask

    // 0x155 and 0x055 differ only in bit 8, so a lost high bit aliases them
    task automatic t_rw();
        logic [8:0] ad [4] = '{9'h000, 9'h1ff, 9'h155, 9'h055};
        logic [7:0] dt [4] = '{8'h5a, 8'ha5, 8'h0f, 8'hf0};
        for (int i = 0; i < 4; i++)
            do_write(ad[i], dt[i], EDA_MODE_ATOMIC, 0);
        for (int i = 0; i < 4; i++)
            do_read(ad[i], dt[i]);
        $display("t_rw done");
    endtask

    task automatic t_guard();
        cpu.io_wr(EDA_OFS_DATA, 8'h77);
        cpu.io_wr(EDA_OFS_CTRL, 8'h02);
        cpu.io_rd(EDA_OFS_CTRL, rd);
        `CHK(rd[EDA_BIT_WRITE_STROBE], 1'b0)
        cpu.io_wr(EDA_OFS_CTRL, 8'h04);
        cpu.io_rd(EDA_OFS_CTRL, rd);
        `CHK(rd[EDA_BIT_MASTER_WE], 1'b1)
        repeat (6) @(negedge CLK);
        cpu.io_rd(EDA_OFS_CTRL, rd);
        `CHK(rd[EDA_BIT_MASTER_WE], 1'b0)
        cpu.io_wr(EDA_OFS_CTRL, 8'h04);
        repeat (6) @(negedge CLK);
        cpu.io_wr(EDA_OFS_CTRL, 8'h02);
        cpu.io_rd(EDA_OFS_CTRL, rd);
        `CHK(rd[EDA_BIT_WRITE_STROBE], 1'b0)
        do_read(9'h055, 8'hf0);
        $display("t_guard done");
    endtask

    // 0x3c merged over 0xa5 by write-only gives 0x24, which no plain write would leave
    task automatic t_modes();
        do_write(9'h0aa, 8'ha5, EDA_MODE_ATOMIC, 2);
        do_read(9'h0aa, 8'ha5);
        do_write(9'h0aa, 8'h00, EDA_MODE_ERASE, 0);
        do_read(9'h0aa, 8'hff);
        do_write(9'h0aa, 8'ha5, EDA_MODE_WRITE_ONLY, 0);
        do_read(9'h0aa, 8'ha5);
        do_write(9'h0aa, 8'h3c, EDA_MODE_WRITE_ONLY, 0);
        do_read(9'h0aa, 8'h24);
        cpu.nv_write(9'h0aa, 8'h11, EDA_MODE_ATOMIC, 3);
        cpu.io_rd(EDA_OFS_CTRL, rd);
        `CHK(rd[EDA_BIT_WRITE_STROBE], 1'b0)
        do_read(9'h0aa, 8'h24);
        $display("t_modes done");
    endtask

    initial
    begin
        CLK       = 1'b0;
        RSTN      = 1'b0;
        err_count = 0;
        checked   = 0;
        repeat (10) @(negedge CLK);
        RSTN = 1'b1;
        t_regs();
        t_rw();
        t_guard();
        t_modes();
        test_done(1'b0);
    end
endmodule
